// ==== wgb_top.sv ====
// Write-back gather buffer: outbound write queue between load/store pipeline and bus
`timescale 1ns/1ps
`include "wgb_regs.svh"

module wgb_top #(
	parameter int NUM_ENT = `WGB_ENTRIES, // Number of line entries
	parameter int IDX_W = $clog2(NUM_ENT) // Entry index width
) (
	input wire logic sys_clk_in,                          // Core clock, 200 MHz
	input wire logic rst_b_in,                            // Synchronous reset, active low
	input wire logic write_through_merge_enable_in,       // Allow write-through merging
	input wire logic st_valid_in,                         // Store request valid
	output logic st_ready_out,                            // Store request can be taken
	input wire wgb_pkg::wgb_kind_t st_kind_in,            // Kind of outbound write
	input wire wgb_pkg::wgb_size_t st_size_in,            // Word or doubleword (gathered)
	input wire logic [31:0] st_addr_in,                   // Byte address
	input wire logic [7:0] st_be_in,                      // Byte enables in the doubleword lane
	input wire logic [63:0] st_data_in,                   // Store data
	input wire logic ld_valid_in,                         // Read request valid
	output logic ld_ready_out,                            // Read request can be taken
	input wire logic [31:0] ld_addr_in,                   // Read address
	input wire logic sync_in,                             // Barrier executed, pulse
	input wire logic exception_in,                        // Exception taken, pulse
	input wire logic prefetch_flush_hint_in,              // Prefetch flush hint, pulse
	input wire logic [31:0] hint_addr_in,                 // Hint address
	output logic bus_valid_out,                           // Bus command valid
	input wire logic bus_ready_in,                        // Bus takes command
	output logic bus_write_out,                           // 1 write, 0 read
	output wgb_pkg::wgb_kind_t bus_kind_out,              // Kind of write
	output logic [31:0] bus_addr_out,                     // Command address
	output logic [`WGB_LINE_BITS-1:0] bus_data_out,       // Line data
	output logic [`WGB_LINE_BE-1:0] bus_be_out            // Line byte enables
);

	// --------------------------------------------------------------
	// Helpers
	// --------------------------------------------------------------
	function automatic logic same_line(input logic [31:0] a, input logic [31:0] b);
		return a[31:`WGB_LINE_LSB] == b[31:`WGB_LINE_LSB];
	endfunction

	// Lowest set bit of a vector
	function automatic logic [IDX_W-1:0] first_idx(input logic [NUM_ENT-1:0] v);
		logic [IDX_W-1:0] r;
		r = '0;
		for (int i = NUM_ENT - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = IDX_W'(i);
			end
		end
		return r;
	endfunction

	// --------------------------------------------------------------
	// Entries
	// --------------------------------------------------------------
	wgb_pkg::wgb_state_t ent_state [NUM_ENT];
	wgb_pkg::wgb_kind_t ent_kind [NUM_ENT];
	logic [31:0] ent_addr [NUM_ENT];
	logic [`WGB_LINE_BITS-1:0] ent_data [NUM_ENT];
	logic [`WGB_LINE_BE-1:0] ent_be [NUM_ENT];
	logic [`WGB_PTR_W-1:0] ent_ptr [NUM_ENT];
	logic [NUM_ENT-1:0] ent_full;
	logic [NUM_ENT-1:0] alloc_v, wr_v, flush_v, free_v, st_flush;
	wgb_pkg::wgb_kind_t alloc_kind;
	logic [1:0] wr_dw, wr_words;
	logic [7:0] wr_be;
	logic [63:0] wr_data;

	genvar g;
	generate
		for (g = 0; g < NUM_ENT; g++) begin : g_ent
			wgb_entry_if eif();
			wgb_entry u_entry (
				.sys_clk_in(sys_clk_in),
				.rst_b_in(rst_b_in),
				.eif(eif.ent)
			);
			// Strobes per entry, write fields broadcast
			assign eif.alloc = alloc_v[g];
			assign eif.alloc_kind = alloc_kind;
			assign eif.alloc_addr = st_addr_in;
			assign eif.wr = wr_v[g];
			assign eif.wr_dw = wr_dw;
			assign eif.wr_be = wr_be;
			assign eif.wr_data = wr_data;
			assign eif.wr_words = wr_words;
			assign eif.flush = flush_v[g];
			assign eif.free_now = free_v[g];
			assign ent_state[g] = eif.state;
			assign ent_kind[g] = eif.kind;
			assign ent_addr[g] = eif.addr;
			assign ent_data[g] = eif.data;
			assign ent_be[g] = eif.be;
			assign ent_ptr[g] = eif.ptr;
			assign ent_full[g] = eif.full;
		end
	endgenerate

	// --------------------------------------------------------------
	// State declarations
	// --------------------------------------------------------------
	logic [NUM_ENT-1:0] want_q, want_d;
	logic rd_pend_q, rd_pend_d;
	logic [31:0] rd_addr_q, rd_addr_d;
	logic st_ready_q, st_ready_d;
	logic ld_ready_q, ld_ready_d;
	logic [IDX_W-1:0] ord_q [NUM_ENT];
	logic [IDX_W-1:0] ord_d [NUM_ENT];
	logic [IDX_W:0] ord_cnt_q, ord_cnt_d;
	logic bus_valid_q, bus_valid_d, bus_write_q, bus_write_d;
	wgb_pkg::wgb_kind_t bus_kind_q, bus_kind_d;
	logic [31:0] bus_addr_q, bus_addr_d;
	logic [`WGB_LINE_BITS-1:0] bus_data_q, bus_data_d;
	logic [`WGB_LINE_BE-1:0] bus_be_q, bus_be_d;
	logic [IDX_W-1:0] bus_idx_q, bus_idx_d;
	logic [NUM_ENT-1:0] open_v, free_cur, wt_live, wt_same, uca_live, uca_same, ev_same;
	logic [`WGB_PTR_W-1:0] uca_ptr, gptr;
	logic rd_block, st_take, ld_take, new_ent, imm, rd_issue, bus_pop;
	logic [IDX_W-1:0] free_idx, hd;

	assign st_take = st_valid_in && st_ready_q;
	assign ld_take = ld_valid_in && ld_ready_q;
	assign free_idx = first_idx(free_cur);

	// --------------------------------------------------------------
	// Entry lookup
	// --------------------------------------------------------------
	// A full or flush-pending entry takes no more merges
	always_comb begin
		open_v = '0;
		free_cur = '0;
		wt_live = '0;
		wt_same = '0;
		uca_live = '0;
		uca_same = '0;
		ev_same = '0;
		uca_ptr = '0;
		rd_block = 1'b0;
		for (int i = 0; i < NUM_ENT; i++) begin
			open_v[i] = ent_state[i] == wgb_pkg::WGB_S_OPEN;
			free_cur[i] = ent_state[i] == wgb_pkg::WGB_S_FREE;
			// Any held write to the read's line goes to the bus first
			if (!free_cur[i] && same_line(ent_addr[i], rd_addr_q)) begin
				rd_block = 1'b1;
			end
			if (open_v[i] && !want_q[i] && !ent_full[i]) begin
				if (ent_kind[i] == wgb_pkg::WGB_K_WT) begin
					wt_live[i] = 1'b1;
					wt_same[i] = same_line(ent_addr[i], st_addr_in);
				end
				if (ent_kind[i] == wgb_pkg::WGB_K_UCA) begin
					uca_live[i] = 1'b1;
					uca_same[i] = same_line(ent_addr[i], st_addr_in);
					if (uca_same[i]) begin
						uca_ptr = ent_ptr[i];
					end
				end
				if (ent_kind[i] == wgb_pkg::WGB_K_EVICT) begin
					ev_same[i] = same_line(ent_addr[i], st_addr_in);
				end
			end
		end
	end

	// --------------------------------------------------------------
	// Store decode
	// --------------------------------------------------------------
	always_comb begin
		alloc_v = '0;
		wr_v = '0;
		st_flush = '0;
		new_ent = 1'b0;
		imm = 1'b0;
		gptr = '0;
		alloc_kind = st_kind_in;
		wr_dw = st_addr_in[`WGB_DW_MSB:`WGB_DW_LSB];
		wr_be = st_be_in;
		wr_data = st_data_in;
		wr_words = '0;
		if (st_take) begin
			case (st_kind_in)
				wgb_pkg::WGB_K_EVICT: begin
					if (|ev_same) begin
						wr_v = ev_same;
					end else begin
						new_ent = 1'b1;
					end
				end
				wgb_pkg::WGB_K_WT: begin
					if (write_through_merge_enable_in && |wt_same) begin
						wr_v = wt_same;
					end else begin
						st_flush = wt_live;
						new_ent = 1'b1;
						imm = !write_through_merge_enable_in;
					end
				end
				wgb_pkg::WGB_K_UCA: begin
					// A doubleword may not sit at an odd word position
					if (|uca_same && !(st_size_in == wgb_pkg::WGB_SZ_DWORD && uca_ptr[0])) begin
						wr_v = uca_same;
						gptr = uca_ptr;
					end else begin
						st_flush = uca_live;
						new_ent = 1'b1;
						if (st_addr_in[`WGB_LINE_LSB-1:0] != '0 || |uca_same) begin
							alloc_kind = wgb_pkg::WGB_K_UNC;
							imm = 1'b1;
						end
					end
					// Gathered stores fill by position, not by address
					if (alloc_kind == wgb_pkg::WGB_K_UCA) begin
						wr_dw = gptr[`WGB_PTR_DW_MSB:`WGB_PTR_DW_LSB];
						if (st_size_in == wgb_pkg::WGB_SZ_WORD) begin
							wr_be = gptr[0] ? `WGB_BE_WORD_HI : `WGB_BE_WORD_LO;
							wr_data = {st_data_in[31:0], st_data_in[31:0]};
							wr_words = `WGB_WORD_STEP;
						end else begin
							wr_be = `WGB_BE_ALL;
							wr_words = `WGB_DWORD_STEP;
						end
					end
				end
				default: begin
					new_ent = 1'b1;
					imm = 1'b1;
				end
			endcase
			if (new_ent) begin
				alloc_v[free_idx] = 1'b1;
				wr_v[free_idx] = 1'b1;
				st_flush[free_idx] = imm;
			end
		end
	end

	// --------------------------------------------------------------
	// Flush selection, order queue, read slot
	// --------------------------------------------------------------
	// Flush wishes are sticky; one entry flushes per cycle so the order queue never races
	always_comb begin
		logic [NUM_ENT-1:0] free_next;
		free_next = '0;
		want_d = want_q | st_flush;
		flush_v = '0;
		ord_d = ord_q;
		ord_cnt_d = ord_cnt_q;
		rd_pend_d = rd_pend_q;
		rd_addr_d = rd_addr_q;
		for (int i = 0; i < NUM_ENT; i++) begin
			if (open_v[i]) begin
				if (rd_pend_q && same_line(ent_addr[i], rd_addr_q) &&
					(ent_kind[i] == wgb_pkg::WGB_K_WT || ent_kind[i] == wgb_pkg::WGB_K_UCA)) begin
					want_d[i] = 1'b1;
				end
				if (ent_kind[i] == wgb_pkg::WGB_K_UCA && (sync_in || exception_in)) begin
					want_d[i] = 1'b1;
				end
				if (ent_kind[i] == wgb_pkg::WGB_K_UCA && prefetch_flush_hint_in &&
					same_line(ent_addr[i], hint_addr_in)) begin
					want_d[i] = 1'b1;
				end
				if (ent_full[i]) begin
					want_d[i] = 1'b1;
				end
			end
		end
		if (bus_pop) begin
			for (int k = 0; k < NUM_ENT - 1; k++) begin
				ord_d[k] = ord_q[k + 1];
			end
			ord_cnt_d = ord_cnt_q - (IDX_W+1)'(1);
		end
		if (|(want_q & open_v)) begin
			flush_v[first_idx(want_q & open_v)] = 1'b1;
			ord_d[ord_cnt_d[IDX_W-1:0]] = first_idx(want_q & open_v);
			ord_cnt_d = ord_cnt_d + (IDX_W+1)'(1);
		end
		want_d = want_d & ~flush_v;
		if (ld_take) begin
			rd_pend_d = 1'b1;
			rd_addr_d = ld_addr_in;
		end
		if (rd_issue) begin
			rd_pend_d = 1'b0;
		end
		for (int i = 0; i < NUM_ENT; i++) begin
			free_next[i] = (free_cur[i] && !alloc_v[i]) || free_v[i];
		end
		st_ready_d = |free_next;
		ld_ready_d = !rd_pend_d;
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			want_q <= '0;
			rd_pend_q <= 1'b0;
			rd_addr_q <= '0;
			st_ready_q <= 1'b0;
			ld_ready_q <= 1'b0;
			ord_q <= '{default: '0};
			ord_cnt_q <= '0;
		end else begin
			want_q <= want_d;
			rd_pend_q <= rd_pend_d;
			rd_addr_q <= rd_addr_d;
			st_ready_q <= st_ready_d;
			ld_ready_q <= ld_ready_d;
			ord_q <= ord_d;
			ord_cnt_q <= ord_cnt_d;
		end
	end

	// --------------------------------------------------------------
	// Bus command register
	// --------------------------------------------------------------
	// Unrelated reads may overtake queued writes; reads carry no buffered data
	always_comb begin
		bus_valid_d = bus_valid_q;
		bus_write_d = bus_write_q;
		bus_kind_d = bus_kind_q;
		bus_addr_d = bus_addr_q;
		bus_data_d = bus_data_q;
		bus_be_d = bus_be_q;
		bus_idx_d = bus_idx_q;
		rd_issue = 1'b0;
		bus_pop = 1'b0;
		free_v = '0;
		hd = ord_q[0];
		if (bus_valid_q && bus_ready_in && bus_write_q) begin
			free_v[bus_idx_q] = 1'b1;
		end
		if (!bus_valid_q || bus_ready_in) begin
			bus_valid_d = 1'b0;
			if (rd_pend_q && !rd_block) begin
				bus_valid_d = 1'b1;
				bus_write_d = 1'b0;
				bus_kind_d = wgb_pkg::WGB_K_UNC;
				bus_addr_d = rd_addr_q;
				bus_data_d = '0;
				bus_be_d = '0;
				rd_issue = 1'b1;
			end else if (ord_cnt_q != '0) begin
				bus_valid_d = 1'b1;
				bus_write_d = 1'b1;
				bus_kind_d = ent_kind[hd];
				bus_addr_d = ent_addr[hd];
				if (ent_kind[hd] == wgb_pkg::WGB_K_EVICT || ent_kind[hd] == wgb_pkg::WGB_K_WT) begin
					bus_addr_d = {ent_addr[hd][31:`WGB_LINE_LSB], {`WGB_LINE_LSB{1'b0}}};
				end
				bus_data_d = ent_data[hd];
				bus_be_d = ent_be[hd];
				bus_idx_d = hd;
				bus_pop = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			bus_valid_q <= 1'b0;
			bus_write_q <= 1'b0;
			bus_kind_q <= wgb_pkg::WGB_K_EVICT;
			bus_addr_q <= '0;
			bus_data_q <= '0;
			bus_be_q <= '0;
			bus_idx_q <= '0;
		end else begin
			bus_valid_q <= bus_valid_d;
			bus_write_q <= bus_write_d;
			bus_kind_q <= bus_kind_d;
			bus_addr_q <= bus_addr_d;
			bus_data_q <= bus_data_d;
			bus_be_q <= bus_be_d;
			bus_idx_q <= bus_idx_d;
		end
	end

	// Outputs straight from flip-flops
	assign st_ready_out = st_ready_q;
	assign ld_ready_out = ld_ready_q;
	assign bus_valid_out = bus_valid_q;
	assign bus_write_out = bus_write_q;
	assign bus_kind_out = bus_kind_q;
	assign bus_addr_out = bus_addr_q;
	assign bus_data_out = bus_data_q;
	assign bus_be_out = bus_be_q;

endmodule

// ==== wgb_regs.svh ====
// Constants for the write-back gather buffer
`ifndef WGB_REGS_SVH
`define WGB_REGS_SVH

`define WGB_ENTRIES 4
`define WGB_LINE_LSB 5
`define WGB_DW_MSB 4
`define WGB_DW_LSB 3
`define WGB_PTR_DW_MSB 2
`define WGB_PTR_DW_LSB 1
`define WGB_PTR_W 4
`define WGB_LINE_BITS 256
`define WGB_LINE_BE 32
`define WGB_BE_WORD_LO 8'h0F
`define WGB_BE_WORD_HI 8'hF0
`define WGB_BE_ALL 8'hFF
`define WGB_WORD_STEP 2'h1
`define WGB_DWORD_STEP 2'h2

`endif

// ==== wgb_pkg.sv ====
// Types shared by the write-back gather buffer modules
package wgb_pkg;

	// Kind of outbound write held by an entry
	typedef enum logic [2:0] {
		WGB_K_EVICT = 3'b000,
		WGB_K_WT = 3'b001,
		WGB_K_UNC = 3'b010,
		WGB_K_UCA = 3'b011,
		WGB_K_L2 = 3'b100
	} wgb_kind_t;

	// Entry life cycle
	typedef enum logic [1:0] {
		WGB_S_FREE = 2'b00,
		WGB_S_OPEN = 2'b01,
		WGB_S_FLUSHED = 2'b10
	} wgb_state_t;

	// Store size for gathered stores
	typedef enum logic {
		WGB_SZ_WORD = 1'b0,
		WGB_SZ_DWORD = 1'b1
	} wgb_size_t;

endpackage

// ==== wgb_entry_if.sv ====
// Control and status bundle between the buffer controller and one entry
`timescale 1ns/1ps
`include "wgb_regs.svh"

interface wgb_entry_if;
	logic alloc;
	wgb_pkg::wgb_kind_t alloc_kind;
	logic [31:0] alloc_addr;
	logic wr;
	logic [1:0] wr_dw;
	logic [7:0] wr_be;
	logic [63:0] wr_data;
	logic [1:0] wr_words;
	logic flush;
	logic free_now;
	wgb_pkg::wgb_state_t state;
	wgb_pkg::wgb_kind_t kind;
	logic [31:0] addr;
	logic [`WGB_LINE_BITS-1:0] data;
	logic [`WGB_LINE_BE-1:0] be;
	logic [`WGB_PTR_W-1:0] ptr;
	logic full;

	modport ctl (output alloc, alloc_kind, alloc_addr, wr, wr_dw, wr_be, wr_data, wr_words, flush, free_now,
		input state, kind, addr, data, be, ptr, full);
	modport ent (input alloc, alloc_kind, alloc_addr, wr, wr_dw, wr_be, wr_data, wr_words, flush, free_now,
		output state, kind, addr, data, be, ptr, full);
endinterface

// ==== wgb_entry.sv ====
// One line-sized entry of the write-back gather buffer
`timescale 1ns/1ps
`include "wgb_regs.svh"

module wgb_entry (
	input wire logic sys_clk_in, // Core clock
	input wire logic rst_b_in,   // Synchronous reset, active low
	wgb_entry_if.ent eif         // Controller side
);

	wgb_pkg::wgb_state_t state_q, state_d;
	wgb_pkg::wgb_kind_t kind_q, kind_d;
	logic [31:0] addr_q, addr_d;
	logic [`WGB_LINE_BITS-1:0] data_q, data_d;
	logic [`WGB_LINE_BE-1:0] be_q, be_d;
	logic [`WGB_PTR_W-1:0] ptr_q, ptr_d;

	// --------------------------------------------------------------
	// Next state and byte merge
	// --------------------------------------------------------------
	always_comb begin
		logic [4:0] byte_ix;
		byte_ix = '0;
		state_d = state_q;
		kind_d = kind_q;
		addr_d = addr_q;
		data_d = data_q;
		be_d = be_q;
		ptr_d = ptr_q;
		case (state_q)
			wgb_pkg::WGB_S_FREE: begin
				if (eif.alloc) begin
					state_d = wgb_pkg::WGB_S_OPEN;
					kind_d = eif.alloc_kind;
					addr_d = eif.alloc_addr;
					data_d = '0;
					be_d = '0;
					ptr_d = '0;
				end
			end
			wgb_pkg::WGB_S_OPEN: begin
				if (eif.flush) begin
					state_d = wgb_pkg::WGB_S_FLUSHED;
				end
			end
			wgb_pkg::WGB_S_FLUSHED: begin
				// Frozen until the bus has taken the data
				if (eif.free_now) begin
					state_d = wgb_pkg::WGB_S_FREE;
				end
			end
			default: begin
				state_d = wgb_pkg::WGB_S_FREE;
			end
		endcase
		// Writes land on the entry being loaded or still open
		if (eif.wr && (eif.alloc || state_q == wgb_pkg::WGB_S_OPEN)) begin
			for (int b = 0; b < 8; b++) begin
				byte_ix = {eif.wr_dw, 3'(b)};
				if (eif.wr_be[b]) begin
					data_d[{byte_ix, 3'h0} +: 8] = eif.wr_data[b*8 +: 8];
					be_d[byte_ix] = 1'b1;
				end
			end
			ptr_d = ptr_d + {2'h0, eif.wr_words};
		end
	end

	// Registers only
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			state_q <= wgb_pkg::WGB_S_FREE;
			kind_q <= wgb_pkg::WGB_K_EVICT;
			addr_q <= '0;
			data_q <= '0;
			be_q <= '0;
			ptr_q <= '0;
		end else begin
			state_q <= state_d;
			kind_q <= kind_d;
			addr_q <= addr_d;
			data_q <= data_d;
			be_q <= be_d;
			ptr_q <= ptr_d;
		end
	end

	// Status back to the controller
	assign eif.state = state_q;
	assign eif.kind = kind_q;
	assign eif.addr = addr_q;
	assign eif.data = data_q;
	assign eif.be = be_q;
	assign eif.ptr = ptr_q;
	assign eif.full = &be_q;

endmodule

// ==== wgb_asserts.sv ====
// Concurrent checks on the ports of the write-back gather buffer
`timescale 1ns/1ps
`include "wgb_regs.svh"

module wgb_asserts (
	input wire logic sys_clk_in, // Clock
	input wire logic rst_b_in, // Reset, low
	input wire logic st_valid_in, // Store valid
	input wire logic st_ready_out, // Store ready
	input wire wgb_pkg::wgb_kind_t st_kind_in, // Store kind
	input wire logic ld_valid_in, // Load valid
	input wire logic ld_ready_out, // Load ready
	input wire logic bus_valid_out, // Command valid
	input wire logic bus_ready_in, // Command taken
	input wire logic bus_write_out, // Write
	input wire wgb_pkg::wgb_kind_t bus_kind_out, // Kind
	input wire logic [31:0] bus_addr_out, // Address
	input wire logic [`WGB_LINE_BITS-1:0] bus_data_out, // Data
	input wire logic [`WGB_LINE_BE-1:0] bus_be_out // Enables
);
	// ----------------------------------------
	// Port relations
	// ----------------------------------------
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_b_in);
	// Write command on the bus; waits are generous since the bus may stall
	logic wr_v;
	logic st_t;
	assign wr_v = bus_valid_out && bus_write_out;
	assign st_t = st_valid_in && st_ready_out;
	reset_idle_a: assert property (disable iff (1'b0)
		!rst_b_in |=> !bus_valid_out && !st_ready_out && !ld_ready_out) else $error("busy after reset");
	kind_legal_a: assert property (wr_v |-> bus_kind_out <= wgb_pkg::WGB_K_L2 &&
		(bus_kind_out != wgb_pkg::WGB_K_WT || bus_addr_out[4:0] == 5'h00)) else $error("bad write kind");
	cmd_hold_a: assert property (bus_valid_out && !bus_ready_in |=>
		bus_valid_out && $stable(bus_addr_out) && $stable(bus_data_out)) else $error("command dropped");
	unc_flush_a: assert property (st_t && st_kind_in == wgb_pkg::WGB_K_UNC |->
		##[2:40] wr_v && bus_kind_out == wgb_pkg::WGB_K_UNC) else $error("uncached not flushed");
	l2_flush_a: assert property (st_t && st_kind_in == wgb_pkg::WGB_K_L2 |->
		##[2:40] wr_v && bus_kind_out == wgb_pkg::WGB_K_L2) else $error("cache command not flushed");
	evict_line_a: assert property (wr_v && bus_kind_out == wgb_pkg::WGB_K_EVICT |->
		bus_be_out == 32'hFFFF_FFFF && bus_addr_out[4:0] == 5'h00) else $error("partial eviction");
	gather_tag_a: assert property (wr_v && bus_kind_out == wgb_pkg::WGB_K_UCA |->
		bus_addr_out[4:0] == 5'h00 && bus_be_out[3:0] == 4'hF) else $error("bad gather tag");
	read_clean_a: assert property (bus_valid_out && !bus_write_out |->
		bus_data_out == '0 && bus_be_out == '0) else $error("read carries data");
	ld_issue_a: assert property (ld_valid_in && ld_ready_out |->
		##[1:60] bus_valid_out && !bus_write_out) else $error("read not issued");
endmodule

// ==== wgb_bus_model.sv ====
// Memory controller stand-in that accepts bus commands
`timescale 1ns/1ps

module wgb_bus_model (
	input wire logic sys_clk_in, // Clock
	input wire logic rst_b_in, // Reset, low
	input wire logic [1:0] mode_in, // 0 prompt, 1 slow, 2 stalled
	output logic ready_out // Accept strobe
);
	// ----------------------------------------
	// Acceptance
	// ----------------------------------------
	// Redrawn off the sampling edge; a full stall only when the bench asks
	initial ready_out = 1'b0;
	always @(negedge sys_clk_in) begin
		if (!rst_b_in || mode_in == 2'h2)
			ready_out <= 1'b0;
		else
			ready_out <= (mode_in == 2'h0) ? ($urandom % 4 != 0) : ($urandom % 4 == 0);
	end
endmodule

// ==== wgb_top_bench.sv ====
// Self-checking bench for the write-back gather buffer
`timescale 1ns/1ps
`include "wgb_regs.svh"

module wgb_top_bench;
	// ----------------------------------------
	// Stimulus, monitor and checks
	// ----------------------------------------
	typedef struct {logic w; wgb_pkg::wgb_kind_t k; logic [31:0] a; logic [31:0] b; logic [255:0] d;} wgb_cmd_t;
	localparam wgb_pkg::wgb_kind_t EV = wgb_pkg::WGB_K_EVICT;
	localparam wgb_pkg::wgb_kind_t WT = wgb_pkg::WGB_K_WT;
	localparam wgb_pkg::wgb_kind_t UN = wgb_pkg::WGB_K_UNC;
	localparam wgb_pkg::wgb_kind_t UA = wgb_pkg::WGB_K_UCA;
	logic clk, rst_b, mrg, sv, sr, lv, lr, syn, exc, hnt, bv, br, bw;
	logic [1:0] mode;
	logic [7:0] sb;
	logic [31:0] sa, la, ha, ba, bbe, a, a2, b;
	logic [63:0] sd, d;
	logic [255:0] bd, ln;
	wgb_pkg::wgb_kind_t sk, bk, k;
	wgb_pkg::wgb_size_t ssz;
	wgb_cmd_t q[$];
	int checks, mismatches, i, j, s;

	wgb_top DUT (.sys_clk_in(clk), .rst_b_in(rst_b), .write_through_merge_enable_in(mrg),
		.st_valid_in(sv), .st_ready_out(sr), .st_kind_in(sk), .st_size_in(ssz), .st_addr_in(sa),
		.st_be_in(sb), .st_data_in(sd), .ld_valid_in(lv), .ld_ready_out(lr), .ld_addr_in(la),
		.sync_in(syn), .exception_in(exc), .prefetch_flush_hint_in(hnt), .hint_addr_in(ha),
		.bus_valid_out(bv), .bus_ready_in(br), .bus_write_out(bw), .bus_kind_out(bk),
		.bus_addr_out(ba), .bus_data_out(bd), .bus_be_out(bbe));
	wgb_bus_model BUS (.sys_clk_in(clk), .rst_b_in(rst_b), .mode_in(mode), .ready_out(br));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Record every command the bus accepts, in acceptance order
	always @(posedge clk) begin
		if (rst_b === 1'b1 && bv === 1'b1 && br === 1'b1)
			q.push_back('{bw, bk, ba, bbe, bd});
	end

	function automatic logic [31:0] lbe(input logic [31:0] a, input logic [7:0] b);
		return {24'h00_0000, b} << {a[4:3], 3'h0};
	endfunction
	function automatic logic [255:0] ldat(input logic [31:0] a, input logic [63:0] d);
		return {192'h0, d} << {a[4:3], 6'h00};
	endfunction
	function automatic logic [255:0] bmask(input logic [31:0] b);
		logic [255:0] m;
		for (int n = 0; n < 32; n++) m[8*n+:8] = {8{b[n]}};
		return m;
	endfunction
	task chk(input logic [255:0] seen, input logic [255:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wq(input int n);
		int t;
		t = 0;
		while (q.size() < n && t < 300) begin
			@(negedge clk);
			t++;
		end
		chk(q.size() >= n, 1'b1);
	endtask
	// Compare the next bus command; bytes off the enables are not compared
	task expc(input logic w, input wgb_pkg::wgb_kind_t k, input logic [31:0] a, b, input logic [255:0] d);
		wgb_cmd_t c;
		wq(1);
		c = q.pop_front();
		chk(c.w, w);
		chk(c.k, k);
		chk(c.a, a);
		chk(c.b, b);
		chk(c.d & bmask(b), d & bmask(b));
	endtask
	// Store valid is left high for back-to-back use; idle lowers it
	task st(input wgb_pkg::wgb_kind_t k, input logic z, input logic [31:0] a, input logic [7:0] b,
		input logic [63:0] d);
		int t;
		t = 0;
		while (sr !== 1'b1 && t < 300) begin
			sv = 1'b0;
			@(negedge clk);
			t++;
		end
		chk(sr, 1'b1);
		sk = k;
		ssz = wgb_pkg::wgb_size_t'(z);
		sa = a;
		sb = b;
		sd = d;
		sv = 1'b1;
		@(negedge clk);
	endtask
	task idle();
		sv = 1'b0;
		@(negedge clk);
	endtask
	task ld(input logic [31:0] a);
		int t;
		t = 0;
		while (lr !== 1'b1 && t < 300) begin
			@(negedge clk);
			t++;
		end
		chk(lr, 1'b1);
		la = a;
		lv = 1'b1;
		@(negedge clk);
		lv = 1'b0;
	endtask
	// One-cycle pulse: 0 barrier, 1 exception, 2 prefetch hint
	task pl(input int s, input logic [31:0] a);
		ha = a;
		{syn, exc, hnt} = 3'h4 >> s;
		@(negedge clk);
		{syn, exc, hnt} = 3'h0;
	endtask
	task final_report();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		{rst_b, mrg, sv, lv, syn, exc, hnt, mode, sb, sa, la, ha, sd} = '0;
		sk = wgb_pkg::WGB_K_EVICT;
		ssz = wgb_pkg::WGB_SZ_WORD;
		checks = 0;
		mismatches = 0;
		void'($urandom(32'h3620_b384));
		repeat (8) @(negedge clk);
		rst_b = 1'b1;
		repeat (3) @(negedge clk);
		chk(sr, 1'b1);
		// Plain uncached stores and cache commands at random
		for (i = 0; i < 8; i++) begin
			mode = 2'($urandom % 2);
			a = $urandom;
			d = {$urandom, $urandom};
			b = $urandom;
			k = i[0] ? wgb_pkg::WGB_K_L2 : UN;
			st(k, 1'b0, a, b[7:0], d);
			idle();
			expc(1'b1, k, a, lbe(a, b[7:0]), ldat(a, d));
		end
		// Eviction stays put until the fourth doubleword
		a = $urandom & 32'hFFFF_FFE0;
		for (j = 0; j < 8; j++) ln[32*j+:32] = $urandom;
		for (j = 0; j < 4; j++) begin
			if (j == 3) begin
				idle();
				repeat (10) @(negedge clk);
				chk(q.size(), 0);
			end
			st(EV, 1'b0, a + 8 * j, 8'hFF, ln[64*j+:64]);
		end
		idle();
		expc(1'b1, EV, a, 32'hFFFF_FFFF, ln);
		// Write-through without, then with merging
		d = {$urandom, $urandom};
		st(WT, 1'b0, a, 8'h0F, d);
		st(WT, 1'b0, a + 8, 8'hF0, d);
		idle();
		expc(1'b1, WT, a, 32'h0000_000F, ldat(a, d));
		expc(1'b1, WT, a, 32'h0000_F000, ldat(a + 8, d));
		mrg = 1'b1;
		a2 = a ^ 32'h0000_0020;
		st(WT, 1'b0, a, 8'h0F, d);
		st(WT, 1'b0, a + 8, 8'hF0, d);
		for (j = 2; j < 6; j++) st(WT, 1'b0, a2 + 8 * (j % 4), 8'hFF, ln[64*(j%4)+:64]);
		idle();
		expc(1'b1, WT, a, 32'h0000_F00F, ldat(a, d) | ldat(a + 8, d));
		expc(1'b1, WT, a2, 32'hFFFF_FFFF, ln);
		// A read to the open merge line goes out behind its write
		st(WT, 1'b0, a, 8'hFF, d);
		idle();
		ld(a);
		chk(lr, 1'b0);
		expc(1'b1, WT, a, 32'h0000_00FF, ldat(a, d));
		expc(1'b0, UN, a, 32'h0, 256'h0);
		// Word gather ignores the word address once started
		for (j = 0; j < 8; j++) st(UA, 1'b0, a + ((j == 0) ? 0 : 4 * ($urandom % 8)), 8'h00, {32'h0, ln[32*j+:32]});
		idle();
		expc(1'b1, UA, a, 32'hFFFF_FFFF, ln);
		// Barrier, exception, hint and matching load each flush a gather
		for (s = 0; s < 4; s++) begin
			a = $urandom & 32'hFFFF_FFE0;
			d = {$urandom, $urandom};
			st(UA, 1'b0, a, 8'h00, d);
			idle();
			if (s == 3)
				ld(a);
			else
				pl(s, a);
			expc(1'b1, UA, a, 32'h0000_000F, {224'h0, d[31:0]});
			if (s == 3)
				expc(1'b0, UN, a, 32'h0, 256'h0);
		end
		// A doubleword landing on an odd position leaves the gather
		st(UA, 1'b1, a, 8'h00, d);
		st(UA, 1'b0, a + 8, 8'h00, d);
		st(UA, 1'b1, a + 16, 8'h00, d);
		idle();
		wq(2);
		i = (q[0].k === UA) ? 0 : 1;
		chk(q[i].b, 32'h0000_0FFF);
		chk(q[1-i].k, UN);
		q.delete();
		// Unaligned start is plain uncached; another line flushes the gather
		st(UA, 1'b0, a + 4, 8'h00, d);
		idle();
		wq(1);
		chk(q[0].k, UN);
		chk(q[0].a, a + 4);
		q.delete();
		st(UA, 1'b0, a, 8'h00, d);
		st(UA, 1'b0, a2, 8'h00, d);
		idle();
		expc(1'b1, UA, a, 32'h0000_000F, {224'h0, d[31:0]});
		pl(0, a2);
		expc(1'b1, UA, a2, 32'h0000_000F, {224'h0, d[31:0]});
		// Four entries busy behind a stalled bus, then drained in order
		mode = 2'h2;
		for (j = 0; j < 4; j++) st(UN, 1'b0, a + 64 * j, 8'hFF, d);
		idle();
		repeat (4) @(negedge clk);
		chk(sr, 1'b0);
		chk(q.size(), 0);
		mode = 2'h0;
		for (j = 0; j < 4; j++) expc(1'b1, UN, a + 64 * j, 32'h0000_00FF, ldat(a, d));
		final_report();
	end
	// Watchdog: the whole sequence needs far fewer cycles than this
	initial begin
		#100000;
		mismatches++;
		final_report();
	end
endmodule

bind wgb_top wgb_asserts u_chk (.sys_clk_in, .rst_b_in, .st_valid_in, .st_ready_out, .st_kind_in, .ld_valid_in,
	.ld_ready_out, .bus_valid_out, .bus_ready_in, .bus_write_out, .bus_kind_out, .bus_addr_out, .bus_data_out,
	.bus_be_out);
